//--- design/bcfg_defines.svh
// offsets, field masks and reset values of the bridge header slice
`ifndef BCFG_DEFINES_SVH
`define BCFG_DEFINES_SVH

`define BCFG_OFF_CLS_DW   8'h0c
`define BCFG_OFF_RSV_LO   8'h10
`define BCFG_OFF_RSV_HI   8'h14
`define BCFG_OFF_BUS_DW   8'h18
`define BCFG_OFF_IO_DW    8'h1c

`define BCFG_ADR_DW       7:2
`define BCFG_B0           7:0
`define BCFG_B1           15:8
`define BCFG_B2           23:16
`define BCFG_B3           31:24
`define BCFG_LANE0        0
`define BCFG_LANE1        1
`define BCFG_LANE2        2
`define BCFG_LANE3        3

`define BCFG_RST_ZERO     8'h00
`define BCFG_RST_IO       8'h01
`define BCFG_HDR_TYPE     8'h01
`define BCFG_HDR_UPPER    8'h00
`define BCFG_CLS_WMASK    8'h3c
`define BCFG_FULL_WMASK   8'hff
`define BCFG_IO_WMASK     8'hf0
`define BCFG_ZERO_BYTE    8'h00
`define BCFG_ZERO_WORD    32'h0000_0000

`endif

//--- design/bcfg_pkg.sv
// types and decode helpers shared by the bridge header slice
`include "bcfg_defines.svh"

package bcfg_pkg;

  typedef logic [7:0]  bcfg_byte_t;
  typedef logic [31:0] bcfg_word_t;
  typedef logic [7:0]  bcfg_adr_t;

  typedef enum logic {
    BCFG_FORWARD,
    BCFG_REVERSE
  } bcfg_mode_e;

  typedef enum logic {
    BCFG_IDLE,
    BCFG_ACK
  } bcfg_bus_e;

  // true when the byte address falls in the dword at off
  function automatic logic bcfg_hit(input bcfg_adr_t adr, input bcfg_adr_t off);
    bcfg_hit = (adr[`BCFG_ADR_DW] == off[`BCFG_ADR_DW]);
  endfunction

  // write enable of one byte field
  function automatic logic bcfg_lane_wr(input logic wr, input logic hit, input logic sel,
                                        input logic allow);
    bcfg_lane_wr = wr & hit & sel & allow;
  endfunction

endpackage

//--- design/bcfg_wb_slave.sv
// classic wishbone handshake: one ack per request, one cycle after it
`timescale 1ns/1ps

module bcfg_wb_slave
  import bcfg_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic cyc_i,
  input  wire logic stb_i,
  input  wire logic we_i,
  output logic      take_o,
  output logic      wr_o,
  output logic      ack_o
);

  bcfg_bus_e state_q;
  bcfg_bus_e state_d;
  logic      ack_q;
  logic      req_w;

  assign req_w  = cyc_i & stb_i;
  assign take_o = req_w & (state_q == BCFG_IDLE);
  assign wr_o   = req_w & we_i & (state_q == BCFG_ACK);
  assign ack_o  = ack_q;

  always_comb begin
    case (state_q)
      BCFG_IDLE: state_d = req_w ? BCFG_ACK : BCFG_IDLE;
      BCFG_ACK:  state_d = BCFG_IDLE;
      default:   state_d = BCFG_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= BCFG_IDLE;
      ack_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      ack_q   <= take_o;
    end
  end

endmodule

//--- design/bcfg_field_reg.sv
// one byte field with a mask of writable bits
`timescale 1ns/1ps

module bcfg_field_reg
  import bcfg_pkg::*;
#(
  parameter bcfg_byte_t RESET = `BCFG_RST_ZERO,
  parameter bcfg_byte_t WMASK = `BCFG_FULL_WMASK
)
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       wr_i,
  input  wire bcfg_byte_t wdata_i,
  output bcfg_byte_t      q_o
);

  bcfg_byte_t q_q;
  bcfg_byte_t q_d;

  // fixed bits keep their value, writable bits take the data
  assign q_d = (q_q & ~WMASK) | (wdata_i & WMASK);
  assign q_o = q_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_q <= RESET;
    end else if (wr_i) begin
      q_q <= q_d;
    end
  end

endmodule

//--- design/bcfg_header.sv
// bridge header dwords 0ch, 10h-17h, 18h and 1ch behind a wishbone slave
//
// Overview of operation
// - cache line bits 5:2 writable, reset zero
// - cache line bits 1:0, 7:6 read zero
// - primary latency writable only reverse with pci
// - secondary latency writable only forward with pci
// - header type bits 22:16 read 0000001
// - bit 23 zero, bits 31:24 read zero
// - offsets 10h to 17h are reserved
// - three writable bus numbers, reset zero
// - io addressing bits read 01, reserved zero
// - io base bits 7:4 writable, reset zero
// - io limit bits 15:12 writable, reset zero
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/1ps

module bcfg_header
  import bcfg_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       wb_cyc_i,
  input  wire logic       wb_stb_i,
  input  wire logic       wb_we_i,
  input  wire bcfg_adr_t  wb_adr_i,
  input  wire logic [3:0] wb_sel_i,
  input  wire bcfg_word_t wb_dat_i,
  output bcfg_word_t      wb_dat_o,
  output logic            wb_ack_o,
  input  wire logic       reverse_mode_i,
  input  wire logic       pri_bus_pci_i,
  input  wire logic       sec_bus_pci_i,
  output bcfg_byte_t      cache_line_size_o,
  output bcfg_byte_t      pri_lat_timer_o,
  output bcfg_byte_t      sec_lat_timer_o,
  output bcfg_byte_t      pri_bus_num_o,
  output bcfg_byte_t      sec_bus_num_o,
  output bcfg_byte_t      sub_bus_num_o,
  output bcfg_byte_t      io_base_o,
  output bcfg_byte_t      io_limit_o
);

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------

  logic       take_w;
  logic       wr_w;
  bcfg_word_t dat_q;
  bcfg_word_t rd_word_w;

  bcfg_wb_slave u_slave (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .cyc_i  (wb_cyc_i),
    .stb_i  (wb_stb_i),
    .we_i   (wb_we_i),
    .take_o (take_w),
    .wr_o   (wr_w),
    .ack_o  (wb_ack_o)
  );

  // ----------------------------------------------------------------
  // address decode and mode
  // ----------------------------------------------------------------

  logic       hit_cls_w;
  logic       hit_rsv_w;
  logic       hit_bus_w;
  logic       hit_io_w;
  bcfg_mode_e mode_w;
  logic       plt_allow_w;
  logic       slt_allow_w;

  assign hit_cls_w = bcfg_hit(wb_adr_i, `BCFG_OFF_CLS_DW);
  // reserved dwords decode but hold nothing
  // reserved space decode
  assign hit_rsv_w = bcfg_hit(wb_adr_i, `BCFG_OFF_RSV_LO) |
                     bcfg_hit(wb_adr_i, `BCFG_OFF_RSV_HI);
  assign hit_bus_w = bcfg_hit(wb_adr_i, `BCFG_OFF_BUS_DW);
  assign hit_io_w  = bcfg_hit(wb_adr_i, `BCFG_OFF_IO_DW);

  assign mode_w = reverse_mode_i ? BCFG_REVERSE : BCFG_FORWARD;

  assign plt_allow_w = (mode_w == BCFG_REVERSE) & pri_bus_pci_i;
  assign slt_allow_w = (mode_w == BCFG_FORWARD) & sec_bus_pci_i;

  // ----------------------------------------------------------------
  // per-field write enables
  // ----------------------------------------------------------------

  logic wr_cls_w;
  logic wr_plt_w;
  logic wr_pbn_w;
  logic wr_sbn_w;
  logic wr_subn_w;
  logic wr_slt_w;
  logic wr_iob_w;
  logic wr_iol_w;

  assign wr_cls_w  = bcfg_lane_wr(wr_w, hit_cls_w, wb_sel_i[`BCFG_LANE0], 1'b1);
  assign wr_plt_w  = bcfg_lane_wr(wr_w, hit_cls_w, wb_sel_i[`BCFG_LANE1], plt_allow_w);
  assign wr_pbn_w  = bcfg_lane_wr(wr_w, hit_bus_w, wb_sel_i[`BCFG_LANE0], 1'b1);
  assign wr_sbn_w  = bcfg_lane_wr(wr_w, hit_bus_w, wb_sel_i[`BCFG_LANE1], 1'b1);
  assign wr_subn_w = bcfg_lane_wr(wr_w, hit_bus_w, wb_sel_i[`BCFG_LANE2], 1'b1);
  assign wr_slt_w  = bcfg_lane_wr(wr_w, hit_bus_w, wb_sel_i[`BCFG_LANE3], slt_allow_w);
  assign wr_iob_w  = bcfg_lane_wr(wr_w, hit_io_w, wb_sel_i[`BCFG_LANE0], 1'b1);
  assign wr_iol_w  = bcfg_lane_wr(wr_w, hit_io_w, wb_sel_i[`BCFG_LANE1], 1'b1);

  // ----------------------------------------------------------------
  // dword 0ch fields
  // ----------------------------------------------------------------

  bcfg_field_reg #(
    .RESET (`BCFG_RST_ZERO),
    .WMASK (`BCFG_CLS_WMASK)
  ) u_cls (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (wr_cls_w),
    .wdata_i (wb_dat_i[`BCFG_B0]),
    .q_o     (cache_line_size_o)
  );

  bcfg_field_reg #(
    .RESET (`BCFG_RST_ZERO),
    .WMASK (`BCFG_FULL_WMASK)
  ) u_plt (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (wr_plt_w),
    .wdata_i (wb_dat_i[`BCFG_B1]),
    .q_o     (pri_lat_timer_o)
  );

  // ----------------------------------------------------------------
  // dword 18h fields
  // ----------------------------------------------------------------

  bcfg_field_reg #(
    .RESET (`BCFG_RST_ZERO),
    .WMASK (`BCFG_FULL_WMASK)
  ) u_pbn (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (wr_pbn_w),
    .wdata_i (wb_dat_i[`BCFG_B0]),
    .q_o     (pri_bus_num_o)
  );

  bcfg_field_reg #(
    .RESET (`BCFG_RST_ZERO),
    .WMASK (`BCFG_FULL_WMASK)
  ) u_sbn (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (wr_sbn_w),
    .wdata_i (wb_dat_i[`BCFG_B1]),
    .q_o     (sec_bus_num_o)
  );

  bcfg_field_reg #(
    .RESET (`BCFG_RST_ZERO),
    .WMASK (`BCFG_FULL_WMASK)
  ) u_subn (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (wr_subn_w),
    .wdata_i (wb_dat_i[`BCFG_B2]),
    .q_o     (sub_bus_num_o)
  );

  bcfg_field_reg #(
    .RESET (`BCFG_RST_ZERO),
    .WMASK (`BCFG_FULL_WMASK)
  ) u_slt (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (wr_slt_w),
    .wdata_i (wb_dat_i[`BCFG_B3]),
    .q_o     (sec_lat_timer_o)
  );

  // ----------------------------------------------------------------
  // dword 1ch fields
  // ----------------------------------------------------------------

  bcfg_field_reg #(
    .RESET (`BCFG_RST_IO),
    .WMASK (`BCFG_IO_WMASK)
  ) u_iob (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (wr_iob_w),
    .wdata_i (wb_dat_i[`BCFG_B0]),
    .q_o     (io_base_o)
  );

  bcfg_field_reg #(
    .RESET (`BCFG_RST_IO),
    .WMASK (`BCFG_IO_WMASK)
  ) u_iol (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (wr_iol_w),
    .wdata_i (wb_dat_i[`BCFG_B1]),
    .q_o     (io_limit_o)
  );

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------

  bcfg_word_t word_cls_w;
  bcfg_word_t word_bus_w;
  bcfg_word_t word_io_w;

  assign word_cls_w = {`BCFG_HDR_UPPER, `BCFG_HDR_TYPE, pri_lat_timer_o,
                       cache_line_size_o};
  assign word_bus_w = {sec_lat_timer_o, sub_bus_num_o, sec_bus_num_o,
                       pri_bus_num_o};
  // upper half of 1ch belongs to secondary status, outside this block
  assign word_io_w  = {`BCFG_ZERO_BYTE, `BCFG_ZERO_BYTE, io_limit_o, io_base_o};

  assign rd_word_w = hit_cls_w ? word_cls_w :
                     hit_bus_w ? word_bus_w :
                     hit_io_w  ? word_io_w  :
                     hit_rsv_w ? `BCFG_ZERO_WORD :
                                 `BCFG_ZERO_WORD;

  assign wb_dat_o = dat_q;

  // read data captured when the request is taken
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= `BCFG_ZERO_WORD;
    end else if (take_w) begin
      dat_q <= wb_we_i ? `BCFG_ZERO_WORD : rd_word_w;
    end
  end

endmodule

//--- verification/bcfg_header_sva.sv
// assertion checker for the bridge header slice
`timescale 1ns/1ps

module bcfg_header_sva
  import bcfg_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire bcfg_adr_t  wb_adr_i,
  input wire bcfg_word_t wb_dat_o,
  input wire logic       wb_ack_o,
  input wire logic       reverse_mode_i,
  input wire logic       pri_bus_pci_i,
  input wire logic       sec_bus_pci_i,
  input wire bcfg_byte_t cache_line_size_o,
  input wire bcfg_byte_t pri_lat_timer_o,
  input wire bcfg_byte_t sec_lat_timer_o,
  input wire bcfg_byte_t io_base_o,
  input wire bcfg_byte_t io_limit_o
);
  // ----------------------------------------
  // request decode and properties
  // ----------------------------------------
  wire take = wb_cyc_i & wb_stb_i & !wb_ack_o;
  wire rd   = take & !wb_we_i;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_pulse_a: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack missing or longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(take))
    else $error("ack without request");
  cls_rsv_a: assert property ((cache_line_size_o & 8'hc3) == 8'h00)
    else $error("cache line reserved bits set");
  io_fixed_a: assert property (io_base_o[3:0] == 4'h1 && io_limit_o[3:0] == 4'h1)
    else $error("io addressing bits wrong");
  pri_ro_a: assert property (!(reverse_mode_i && pri_bus_pci_i)
    |=> $stable(pri_lat_timer_o))
    else $error("primary latency changed while read-only");
  sec_ro_a: assert property (reverse_mode_i || !sec_bus_pci_i |=> $stable(sec_lat_timer_o))
    else $error("secondary latency changed while read-only");
  hdr_read_a: assert property (rd && wb_adr_i[7:2] == 6'h03
    |=> wb_dat_o[31:16] == 16'h0001)
    else $error("header type read wrong");
  rsv_read_a: assert property (rd && wb_adr_i[7:3] == 5'h02 |=> wb_dat_o == 32'h0000_0000)
    else $error("reserved dword read not zero");
  io_read_a: assert property (rd && wb_adr_i[7:2] == 6'h07
    |=> wb_dat_o == {16'h0000, io_limit_o, io_base_o})
    else $error("io dword read wrong");
  cls_write_a: assert property ($changed(cache_line_size_o) |-> $past(wb_ack_o & wb_we_i))
    else $error("cache line changed without write");

  cover property (rd && wb_adr_i[7:2] == 6'h07);
  cover property (wb_ack_o && wb_we_i);
  cover property (wb_ack_o && reverse_mode_i && pri_bus_pci_i);
endmodule

bind bcfg_header bcfg_header_sva u_bcfg_header_sva (.*);

//--- verification/bcfg_header_test.sv
// self-checking bench for the bridge header slice
`timescale 1ns/1ps

module bcfg_header_test
  import bcfg_pkg::*;
;
  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  logic       clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic       reverse_mode_i = 1'b0, pri_bus_pci_i = 1'b0, sec_bus_pci_i = 1'b1;
  logic [3:0] wb_sel_i = 4'h0;
  bcfg_adr_t  wb_adr_i = 8'h00;
  bcfg_word_t wb_dat_i = 32'h0000_0000, wb_dat_o, rdat;
  logic       wb_ack_o;
  bcfg_byte_t cache_line_size_o, pri_lat_timer_o, sec_lat_timer_o, pri_bus_num_o;
  bcfg_byte_t sec_bus_num_o, sub_bus_num_o, io_base_o, io_limit_o;
  int         failures = 0, checks_done = 0, cycles = 0;

  bcfg_header u_bcfg_header (.*);

  always #2.5 clk_i = ~clk_i;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      end_sim();
    end
  end

  task automatic chk(input bcfg_word_t got, input bcfg_word_t exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input bcfg_adr_t a, input logic [3:0] s,
                     input bcfg_word_t d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clk_i);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic wr(input bcfg_adr_t a, input logic [3:0] s, input bcfg_word_t d);
    bus(1'b1, a, s, d);
  endtask

  task automatic rd(input bcfg_adr_t a, input bcfg_word_t e);
    bus(1'b0, a, 4'hf, 32'h0000_0000);
    chk(rdat, e);
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h0c, 32'h0001_0000);
    rd(8'h18, 32'h0000_0000);
    rd(8'h1c, 32'h0000_0101);
    $display("reset values done");
    wr(8'h0c, 4'hf, 32'hffff_ffff);
    rd(8'h0c, 32'h0001_003c);
    chk({24'h0, cache_line_size_o}, 32'h0000_003c);
    wr(8'h18, 4'hf, 32'hffff_ffff);
    rd(8'h18, 32'hffff_ffff);
    chk({sec_lat_timer_o, sub_bus_num_o, sec_bus_num_o, pri_bus_num_o}, 32'hffff_ffff);
    wr(8'h1c, 4'hf, 32'hffff_ffff);
    rd(8'h1c, 32'h0000_f1f1);
    chk({16'h0, io_limit_o, io_base_o}, 32'h0000_f1f1);
    wr(8'h18, 4'h2, 32'h1234_5600);
    rd(8'h18, 32'hffff_56ff);
    wr(8'h10, 4'hf, 32'hffff_ffff);
    rd(8'h10, 32'h0000_0000);
    rd(8'h14, 32'h0000_0000);
    rd(8'h40, 32'h0000_0000);
    $display("write and lanes done");
    reverse_mode_i <= 1'b1;
    pri_bus_pci_i  <= 1'b1;
    wr(8'h0c, 4'hf, 32'hffff_a5c3);
    rd(8'h0c, 32'h0001_a500);
    chk({24'h0, pri_lat_timer_o}, 32'h0000_00a5);
    wr(8'h18, 4'h8, 32'h1100_0000);
    rd(8'h18, 32'hffff_56ff);
    pri_bus_pci_i <= 1'b0;
    wr(8'h0c, 4'h2, 32'h0000_1100);
    rd(8'h0c, 32'h0001_a500);
    reverse_mode_i <= 1'b0;
    sec_bus_pci_i  <= 1'b0;
    wr(8'h18, 4'h8, 32'h0000_0000);
    rd(8'h18, 32'hffff_56ff);
    for (int i = 2; i < 6; i++) begin
      wr(8'h0c, 4'h1, 32'h0000_0001 << i);
      rd(8'h0c, 32'h0001_a500 | (32'h0000_0001 << i));
    end
    $display("mode tests done");
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h0c, 32'h0001_0000);
    rd(8'h18, 32'h0000_0000);
    rd(8'h1c, 32'h0000_0101);
    $display("second reset done");
    end_sim();
  end
endmodule
